//--- logic/pci_bus_port.sv
// Operation
// R1: Host mode: grants one and two serve requests one and two.
// R2: Host mode: grant three serves request three.
// R3: Host mode: the three request pins are active-low master requests.
// R4: Guest mode: grant pin one is the device's own active-low bus request.
// R5: Guest mode: request pin one is the grant; master only once granted.
// R6: Guest mode: request and grant pins two and three are unused.
// R7: A transaction is one address phase then data phases on 32-bit bus.
// R8: Master drives write data; target drives read data; bursts both ways.
// R9: Reads put one turnaround cycle between address and first data phase.
// R10: The command sits on the byte-enable lines in the first clock.
// R11: Each data phase carries byte enables on the command lines.
// R12: Parity makes ones across data, byte enables and parity even.
// R13: Parity driven for own address, own write data, target read data.
// R14: Parity checked on master reads, foreign addresses and target writes.
// R15: Address parity error pulls system error low two clocks later.
// R16: A data phase ends only when both ready signals are low.
// R17: At most one grant at a time, chosen by rotating priority.
// R18: Parity follows its address or data phase by one clock.
`timescale 1ns/1ps
module pci_bus_port (
	input wire logic ref_clk, // Bus clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic host_mode_pin, // Strap: high selects host bridge mode.
	input wire logic request_one_or_guest_grant_n, // Request one, or grant in guest mode.
	input wire logic request_two_n, // Request two.
	input wire logic request_three_n, // Request three.
	output logic grant_one_or_guest_request_n, // Grant one, or own request in guest mode.
	output logic grant_two_n, // Grant two.
	output logic grant_three_n, // Grant three.
	input wire logic [pci_port_pkg::DATA_W-1:0] pad_in, // Address/data wire level.
	output logic [pci_port_pkg::DATA_W-1:0] pad_out, // Address/data drive value.
	output logic pad_oe, // Address/data drive enable.
	input wire logic [pci_port_pkg::CBE_W-1:0] cmd_byte_enable_n_in, // Command lines level.
	output logic [pci_port_pkg::CBE_W-1:0] cmd_byte_enable_n_out, // Command lines value.
	output logic cmd_byte_enable_oe, // Command lines drive enable.
	input wire logic par_in, // Parity wire level.
	output logic par_out, // Parity drive value.
	output logic par_oe, // Parity drive enable.
	input wire logic frame_n_in, // Frame wire level.
	output logic frame_n_out, // Frame drive value.
	output logic frame_oe, // Frame drive enable.
	input wire logic initiator_ready_n_in, // Initiator ready wire level.
	output logic initiator_ready_n_out, // Initiator ready drive value.
	output logic initiator_ready_oe, // Initiator ready drive enable.
	input wire logic target_ready_n, // Target ready wire level.
	output logic system_error_n, // System error, active low.
	input wire logic mst_start, // Pulse: start a master transaction.
	input wire logic mst_write, // Transaction is a write.
	input wire logic [pci_port_pkg::CBE_W-1:0] mst_cmd, // Bus command.
	input wire logic [pci_port_pkg::DATA_W-1:0] mst_addr, // Start address.
	input wire logic [pci_port_pkg::CNT_W-1:0] mst_count, // Data phases, zero means one.
	input wire logic [pci_port_pkg::DATA_W-1:0] mst_wdata, // Write word for mst_phase.
	input wire logic [pci_port_pkg::CBE_W-1:0] mst_be_n, // Byte enables for mst_phase.
	output logic mst_busy, // Master transaction in progress.
	output logic [pci_port_pkg::CNT_W-1:0] mst_phase, // Index of the current data phase.
	output logic mst_ack, // Pulse: a data phase completed.
	output logic [pci_port_pkg::DATA_W-1:0] mst_rdata, // Last read word.
	output logic data_parity_err, // Pulse: data parity error seen.
	input wire logic tgt_rd_drive, // Target side drives read data.
	input wire logic [pci_port_pkg::DATA_W-1:0] tgt_rdata, // Target read data.
	input wire logic tgt_wr_phase // Target side is in a write data phase.
);
	pci_port_pkg::mst_state_t state_r;
	logic mode_s1_r, mode_s2_r, mode_s3_r, host_r;
	logic frame_prev_r;
	logic wr_r;
	logic [pci_port_pkg::CBE_W-1:0] cmd_r;
	logic [pci_port_pkg::DATA_W-1:0] addr_r;
	logic [pci_port_pkg::CNT_W-1:0] cnt_r, phase_r;
	logic [pci_port_pkg::DATA_W-1:0] pad_out_r, rdata_r;
	logic [pci_port_pkg::CBE_W-1:0] cbe_out_r;
	logic pad_oe_r, cbe_oe_r, frame_n_r, frame_oe_r, irdy_n_r, irdy_oe_r;
	logic busy_r, ack_r;
	logic [pci_port_pkg::ARB_W-1:0] arb_req, gnt_n;
	logic bus_idle, granted, go, done_phase, last_phase;

	parity_if pb ();

	pci_arbiter u_arb (
		.clk(ref_clk),
		.rst(sys_rst),
		.host(host_r),
		.guest_req(state_r == pci_port_pkg::ST_REQ),
		.req(arb_req),
		.gnt_n_r(gnt_n)
	);

	pci_parity u_par (
		.clk(ref_clk),
		.rst(sys_rst),
		.pb(pb.unit)
	);

	// The strap comes from outside; it counts once the last two stages agree.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_s1_r <= 1'b0;
			mode_s2_r <= 1'b0;
			mode_s3_r <= 1'b0;
			host_r <= 1'b0;
		end else begin
			mode_s1_r <= host_mode_pin;
			mode_s2_r <= mode_s1_r;
			mode_s3_r <= mode_s2_r;
			if (mode_s2_r == mode_s3_r) begin
				host_r <= mode_s3_r;
			end
		end
	end

	// Request pins are bus-synchronous and go straight to the arbiter.
	assign arb_req = host_r ? {state_r == pci_port_pkg::ST_REQ, ~request_three_n,
		~request_two_n, ~request_one_or_guest_grant_n} : '0; // [R3] [R6]
	assign bus_idle = frame_n_in & initiator_ready_n_in;
	assign granted = host_r ? ~gnt_n[pci_port_pkg::SLOT_OWN] : ~request_one_or_guest_grant_n; // [R5]
	assign go = (state_r == pci_port_pkg::ST_REQ) && granted && bus_idle; // [R5]
	assign done_phase = (state_r == pci_port_pkg::ST_DATA) && !target_ready_n && !irdy_n_r; // [R16]
	assign last_phase = cnt_r == pci_port_pkg::CNT_ONE;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= pci_port_pkg::ST_IDLE;
		end else begin
			case (state_r)
				pci_port_pkg::ST_IDLE: if (mst_start) state_r <= pci_port_pkg::ST_REQ;
				pci_port_pkg::ST_REQ: if (go) state_r <= pci_port_pkg::ST_ADDR;
				pci_port_pkg::ST_ADDR: state_r <= pci_port_pkg::ST_LOAD; // [R7] [R9]
				pci_port_pkg::ST_LOAD: state_r <= pci_port_pkg::ST_DATA;
				pci_port_pkg::ST_DATA: begin
					if (done_phase) begin
						state_r <= last_phase ? pci_port_pkg::ST_DONE : pci_port_pkg::ST_LOAD;
					end
				end
				pci_port_pkg::ST_DONE: state_r <= pci_port_pkg::ST_IDLE;
				default: state_r <= pci_port_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_r <= 1'b0;
			cmd_r <= pci_port_pkg::CBE_RST;
			addr_r <= pci_port_pkg::PAD_RST;
			cnt_r <= pci_port_pkg::CNT_ONE;
			phase_r <= pci_port_pkg::CNT_ZERO;
		end else if (state_r == pci_port_pkg::ST_IDLE && mst_start) begin
			wr_r <= mst_write;
			cmd_r <= mst_cmd;
			addr_r <= mst_addr;
			cnt_r <= (mst_count == pci_port_pkg::CNT_ZERO) ? pci_port_pkg::CNT_ONE : mst_count;
			phase_r <= pci_port_pkg::CNT_ZERO;
		end else if (done_phase) begin
			cnt_r <= cnt_r - pci_port_pkg::CNT_ONE; // [R8]
			phase_r <= phase_r + pci_port_pkg::CNT_ONE;
		end
	end

	// Frame and initiator ready; both stay driven high through the done cycle.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			frame_n_r <= 1'b1;
			frame_oe_r <= 1'b0;
			irdy_n_r <= 1'b1;
			irdy_oe_r <= 1'b0;
		end else if (go) begin
			frame_n_r <= 1'b0;
			frame_oe_r <= 1'b1;
			irdy_oe_r <= 1'b1;
		end else if (state_r == pci_port_pkg::ST_LOAD) begin
			frame_n_r <= last_phase;
			irdy_n_r <= 1'b0;
		end else if (done_phase) begin
			irdy_n_r <= 1'b1; // [R16]
		end else if (state_r == pci_port_pkg::ST_DONE) begin
			frame_oe_r <= 1'b0;
			irdy_oe_r <= 1'b0;
		end
	end

	// Address/data and command lines.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pad_out_r <= pci_port_pkg::PAD_RST;
			pad_oe_r <= 1'b0;
			cbe_out_r <= pci_port_pkg::CBE_RST;
			cbe_oe_r <= 1'b0;
		end else if (go) begin
			pad_out_r <= addr_r; // [R7]
			pad_oe_r <= 1'b1;
			cbe_out_r <= cmd_r; // [R10]
			cbe_oe_r <= 1'b1;
		end else if (state_r == pci_port_pkg::ST_ADDR) begin
			pad_oe_r <= wr_r; // [R9]
		end else if (state_r == pci_port_pkg::ST_LOAD) begin
			if (wr_r) begin
				pad_out_r <= mst_wdata; // [R8]
			end
			cbe_out_r <= mst_be_n; // [R11]
		end else if (done_phase && last_phase) begin
			pad_oe_r <= 1'b0;
			cbe_oe_r <= 1'b0;
		end else if (state_r == pci_port_pkg::ST_IDLE) begin
			pad_out_r <= tgt_rdata; // [R8]
			pad_oe_r <= tgt_rd_drive; // [R13]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
			ack_r <= 1'b0;
			rdata_r <= pci_port_pkg::PAD_RST;
			frame_prev_r <= 1'b1;
		end else begin
			if (state_r == pci_port_pkg::ST_IDLE && mst_start) begin
				busy_r <= 1'b1;
			end else if (state_r == pci_port_pkg::ST_DONE) begin
				busy_r <= 1'b0;
			end
			ack_r <= done_phase; // [R16]
			if (done_phase && !wr_r) begin
				rdata_r <= pad_in; // [R8]
			end
			frame_prev_r <= frame_n_in;
		end
	end

	assign pb.gen_pad = pad_out_r;
	assign pb.gen_cbe = cbe_out_r;
	assign pb.gen_drive = pad_oe_r; // [R13]
	assign pb.chk_pad = pad_in;
	assign pb.chk_cbe = cmd_byte_enable_n_in;
	assign pb.chk_addr = !frame_n_in && frame_prev_r && state_r != pci_port_pkg::ST_ADDR; // [R14]
	assign pb.chk_data = (done_phase && !wr_r) ||
		(tgt_wr_phase && !initiator_ready_n_in && !target_ready_n); // [R14]
	assign pb.par_in = par_in;

	assign grant_one_or_guest_request_n = gnt_n[pci_port_pkg::SLOT_ONE];
	assign grant_two_n = gnt_n[pci_port_pkg::SLOT_TWO];
	assign grant_three_n = gnt_n[pci_port_pkg::SLOT_THREE];
	assign pad_out = pad_out_r;
	assign pad_oe = pad_oe_r;
	assign cmd_byte_enable_n_out = cbe_out_r;
	assign cmd_byte_enable_oe = cbe_oe_r;
	assign par_out = pb.par_out;
	assign par_oe = pb.par_oe;
	assign frame_n_out = frame_n_r;
	assign frame_oe = frame_oe_r;
	assign initiator_ready_n_out = irdy_n_r;
	assign initiator_ready_oe = irdy_oe_r;
	assign system_error_n = pb.serr_n;
	assign mst_busy = busy_r;
	assign mst_phase = phase_r;
	assign mst_ack = ack_r;
	assign mst_rdata = rdata_r;
	assign data_parity_err = pb.data_err;

	sequence read_start_s;
		state_r == pci_port_pkg::ST_ADDR && !wr_r;
	endsequence
	sequence turn_s;
		!pad_oe_r && irdy_n_r ##1 state_r == pci_port_pkg::ST_DATA && !pad_oe_r;
	endsequence
	start_grant_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R4] [R5]
		state_r == pci_port_pkg::ST_ADDR |-> $past(granted) && $past(bus_idle))
		else $error("address phase without grant");
	addr_cmd_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R7] [R10]
		state_r == pci_port_pkg::ST_ADDR |-> !frame_n_r && pad_oe_r && cbe_oe_r &&
		pad_out_r == addr_r && cbe_out_r == cmd_r) else $error("bad address phase");
	read_turn_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R9]
		read_start_s |=> turn_s) else $error("missing read turnaround");
	data_be_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R11]
		state_r == pci_port_pkg::ST_LOAD ##1 state_r == pci_port_pkg::ST_DATA |->
		cbe_oe_r && cbe_out_r == $past(mst_be_n)) else $error("byte enables wrong");
	write_data_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R8]
		state_r == pci_port_pkg::ST_LOAD && wr_r |=> pad_oe_r && pad_out_r == $past(mst_wdata))
		else $error("write data not driven");
	phase_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R16]
		ack_r |-> $past(state_r == pci_port_pkg::ST_DATA && !target_ready_n && !irdy_n_r))
		else $error("phase completed without both readies");
	par_even_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R12] [R13] [R18]
		pad_oe_r |=> par_oe && !(^{$past(pad_out_r), $past(cbe_out_r), par_out}))
		else $error("parity wrong or late");

endmodule : pci_bus_port

//--- logic/pci_port_pkg.sv
package pci_port_pkg;

	localparam int DATA_W = 32;
	localparam int CBE_W = 4;
	localparam int CNT_W = 8;
	localparam int ARB_W = 4;
	// Arbiter slots 0..2 serve the external request pins, slot 3 the device's own master.
	localparam int SLOT_ONE = 0;
	localparam int SLOT_TWO = 1;
	localparam int SLOT_THREE = 2;
	localparam int SLOT_OWN = 3;
	localparam logic [ARB_W-1:0] GNT_NONE_N = 4'hF;
	localparam logic [2:0] GNT_HIGH3_N = 3'h7;
	localparam logic [DATA_W-1:0] PAD_RST = 32'h0000_0000;
	localparam logic [CBE_W-1:0] CBE_RST = 4'hF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	// Address parity error shows on the system error output this many clocks after the phase.
	localparam int SERR_LAG = 2;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_REQ = 6'h02,
		ST_ADDR = 6'h04,
		ST_LOAD = 6'h08,
		ST_DATA = 6'h10,
		ST_DONE = 6'h20
	} mst_state_t;

endpackage : pci_port_pkg

//--- logic/parity_if.sv
`timescale 1ns/1ps
interface parity_if;
	logic [pci_port_pkg::DATA_W-1:0] gen_pad;
	logic [pci_port_pkg::CBE_W-1:0] gen_cbe;
	logic gen_drive;
	logic [pci_port_pkg::DATA_W-1:0] chk_pad;
	logic [pci_port_pkg::CBE_W-1:0] chk_cbe;
	logic chk_addr;
	logic chk_data;
	logic par_in;
	logic par_out;
	logic par_oe;
	logic serr_n;
	logic data_err;
	modport port (output gen_pad, gen_cbe, gen_drive, chk_pad, chk_cbe, chk_addr, chk_data,
		par_in, input par_out, par_oe, serr_n, data_err);
	modport unit (input gen_pad, gen_cbe, gen_drive, chk_pad, chk_cbe, chk_addr, chk_data,
		par_in, output par_out, par_oe, serr_n, data_err);
endinterface : parity_if

//--- logic/pci_arbiter.sv
`timescale 1ns/1ps
module pci_arbiter (
	input wire logic clk, // Bus clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic host, // High in host bridge mode.
	input wire logic guest_req, // Own master wants the bus in guest mode.
	input wire logic [pci_port_pkg::ARB_W-1:0] req, // Requests, active high.
	output logic [pci_port_pkg::ARB_W-1:0] gnt_n_r // Grants, active low.
);
	logic [1:0] last_r;
	logic [1:0] pick;
	logic found;
	logic keep;
	logic [1:0] idx;

	assign keep = |(~gnt_n_r & req);

	// Search starts just after the last winner, so every requester gets its turn.
	always_comb begin
		idx = 2'h0;
		pick = last_r;
		found = 1'b0;
		for (int k = 1; k <= pci_port_pkg::ARB_W; k++) begin
			idx = last_r + 2'(k);
			if (!found && req[idx]) begin
				pick = idx;
				found = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gnt_n_r <= pci_port_pkg::GNT_NONE_N;
			last_r <= 2'h0;
		end else if (!host) begin
			gnt_n_r <= {pci_port_pkg::GNT_HIGH3_N, ~guest_req}; // [R4] [R6]
		end else if (!keep) begin
			gnt_n_r <= pci_port_pkg::GNT_NONE_N;
			if (found) begin
				gnt_n_r[pick] <= 1'b0; // [R1] [R2] [R17]
				last_r <= pick;
			end
		end
	end

	one_grant_a: assert property (@(posedge clk) disable iff (rst) // [R17]
		$onehot0(~gnt_n_r)) else $error("more than one grant asserted");
	grant_cause_a: assert property (@(posedge clk) disable iff (rst) // [R1] [R2] [R3]
		host && $past(host) && gnt_n_r != pci_port_pkg::GNT_NONE_N |-> |($past(req) & ~gnt_n_r))
		else $error("grant without a request");
	guest_quiet_a: assert property (@(posedge clk) disable iff (rst) // [R6]
		!host |=> gnt_n_r[3:1] == pci_port_pkg::GNT_HIGH3_N) else $error("reserved grant used");
	guest_req_a: assert property (@(posedge clk) disable iff (rst) // [R4]
		!host ##0 guest_req |=> !gnt_n_r[pci_port_pkg::SLOT_ONE])
		else $error("guest request not driven");

endmodule : pci_arbiter

//--- logic/pci_parity.sv
`timescale 1ns/1ps
module pci_parity (
	input wire logic clk, // Bus clock.
	input wire logic rst, // Asynchronous reset, active high.
	parity_if.unit pb // Parity generation and check signals.
);
	logic hold_r;
	logic addr_pend_r;
	logic data_pend_r;
	logic bad;
	logic par_out_r;
	logic par_oe_r;
	logic serr_n_r;
	logic data_err_r;

	assign bad = hold_r ^ pb.par_in; // [R12]
	assign pb.par_out = par_out_r;
	assign pb.par_oe = par_oe_r;
	assign pb.serr_n = serr_n_r;
	assign pb.data_err = data_err_r;

	// Parity follows the phase it covers by one clock.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			par_out_r <= 1'b0;
			par_oe_r <= 1'b0;
		end else begin
			par_out_r <= ^{pb.gen_pad, pb.gen_cbe}; // [R12] [R18]
			par_oe_r <= pb.gen_drive; // [R13]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_r <= 1'b0;
			addr_pend_r <= 1'b0;
			data_pend_r <= 1'b0;
			serr_n_r <= 1'b1;
			data_err_r <= 1'b0;
		end else begin
			hold_r <= ^{pb.chk_pad, pb.chk_cbe};
			addr_pend_r <= pb.chk_addr; // [R14]
			data_pend_r <= pb.chk_data; // [R14]
			serr_n_r <= ~(addr_pend_r & bad); // [R15]
			data_err_r <= data_pend_r & bad;
		end
	end

	sequence addr_bad_s;
		pb.chk_addr ##1 (^{$past(pb.chk_pad), $past(pb.chk_cbe), pb.par_in});
	endsequence
	serr_two_a: assert property (@(posedge clk) disable iff (rst) // [R15]
		addr_bad_s |=> !serr_n_r) else $error("address parity error not reported");
	serr_cause_a: assert property (@(posedge clk) disable iff (rst) // [R15]
		!serr_n_r |-> $past(pb.chk_addr, pci_port_pkg::SERR_LAG))
		else $error("system error without address phase");
	data_chk_a: assert property (@(posedge clk) disable iff (rst) // [R14]
		pb.chk_data ##1 bad |=> data_err_r) else $error("data parity error missed");

endmodule : pci_parity

//--- sim/pci_far_model.sv
`timescale 1ns/1ps
module pci_far_model (
	input wire logic ref_clk, // Bus clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic host, // High when the device is in host bridge mode.
	input wire logic req_n, // Device's own request pin in guest mode.
	input wire logic frame_n, // Frame wire.
	input wire logic irdy_n, // Initiator ready wire.
	input wire logic [3:0] cbe_n, // Command and byte enable wire.
	input wire logic [3:0] trdy_wait, // Wait cycles before target ready.
	input wire logic [3:0] gnt_wait, // Wait cycles before the grant.
	input wire logic [31:0] rd_base, // Read word of phase zero.
	output logic gnt_n, // Grant to the device in guest mode.
	output logic target_ready_n, // Target ready, active low.
	output logic [31:0] m_pad, // Read data drive value.
	output logic m_pad_oe, // Read data drive enable.
	output logic m_par, // Read parity drive value.
	output logic m_par_oe // Read parity drive enable.
);
	logic active;
	logic rd;
	logic frame_prev;
	logic [7:0] idx;
	logic [3:0] cnt;
	logic [3:0] gcnt;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			active <= 1'b0;
			rd <= 1'b0;
			frame_prev <= 1'b1;
			idx <= 8'h00;
			cnt <= 4'h0;
			target_ready_n <= 1'b1;
			m_pad_oe <= 1'b0;
			m_pad <= 32'h0000_0000;
		end else begin
			frame_prev <= frame_n;
			m_pad_oe <= 1'b0;
			if (!frame_n && frame_prev) begin
				active <= 1'b1;
				rd <= !cbe_n[0];
				idx <= 8'h00;
				cnt <= 4'h0;
			end else if (active && !irdy_n) begin
				if (!target_ready_n) begin
					target_ready_n <= 1'b1;
					cnt <= 4'h0;
					idx <= idx + 8'h01;
					if (frame_n) begin
						active <= 1'b0;
					end
				end else if (cnt == trdy_wait) begin
					target_ready_n <= 1'b0;
					m_pad_oe <= rd;
					m_pad <= rd_base + {24'h000000, idx};
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end

	// The target covers its own read word with parity one clock later.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			m_par_oe <= 1'b0;
			m_par <= 1'b0;
		end else begin
			m_par_oe <= m_pad_oe;
			m_par <= ^{m_pad, cbe_n};
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gnt_n <= 1'b1;
			gcnt <= 4'h0;
		end else if (host || req_n) begin
			gnt_n <= 1'b1;
			gcnt <= 4'h0;
		end else if (gcnt == gnt_wait) begin
			gnt_n <= 1'b0;
		end else begin
			gcnt <= gcnt + 4'h1;
		end
	end
endmodule : pci_far_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic ref_clk, sys_rst, host_mode_pin, mst_start, mst_write, tgt_rd_drive;
	logic [2:0] req_n;
	logic grant_one_or_guest_request_n, grant_two_n, grant_three_n, system_error_n;
	logic [31:0] pad_out, pad_w, pad_hold, mst_addr, mst_rdata, tgt_rdata, xaddr, rd_base, m_pad;
	logic [31:0] f_pad, seed, prev_pad;
	logic [3:0] cbe_out, cbe_w, cbe_hold, mst_cmd, f_cbe, cap_cmd, prev_cbe, trdy_wait, gnt_wait;
	logic [7:0] mst_count, mst_phase;
	logic pad_oe, cbe_oe, par_out, par_oe, par_w, par_hold, frame_n_out, frame_oe, irdy_out, irdy_oe;
	logic m_gnt_n, trdy_n, m_pad_oe, m_par, m_par_oe, f_oe, f_par, f_par_oe, frame_prev;
	logic mst_busy, mst_ack, data_parity_err, frame_w, irdy_w;
	logic [31:0] cap_addr, wq[$];
	logic [3:0] bq[$];
	logic [3:0] cmds[6] = '{4'h6, 4'h7, 4'h2, 4'h3, 4'hA, 4'hB};
	int n_mismatch = 0;
	int checks_done = 0;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [31:0] wword(input logic [31:0] a, input logic [7:0] k);
		return a ^ {4{k}};
	endfunction : wword

	function automatic logic [3:0] bexp(input logic [31:0] a, input logic [7:0] k);
		return a[3:0] ^ k[3:0];
	endfunction : bexp

	// Lines left undriven show the inverse of their last level; frame and ready have pull-ups.
	assign pad_w = pad_oe ? pad_out : m_pad_oe ? m_pad : f_oe ? f_pad : pad_hold;
	assign cbe_w = cbe_oe ? cbe_out : f_oe ? f_cbe : cbe_hold;
	assign par_w = par_oe ? par_out : m_par_oe ? m_par : f_par_oe ? f_par : par_hold;
	assign frame_w = frame_oe ? frame_n_out : !f_oe;
	assign irdy_w = irdy_oe ? irdy_out : 1'b1;

	pci_bus_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_mode_pin(host_mode_pin),
		.request_one_or_guest_grant_n(host_mode_pin ? req_n[0] : m_gnt_n),
		.request_two_n(req_n[1]), .request_three_n(req_n[2]),
		.grant_one_or_guest_request_n(grant_one_or_guest_request_n),
		.grant_two_n(grant_two_n), .grant_three_n(grant_three_n), .pad_in(pad_w),
		.pad_out(pad_out), .pad_oe(pad_oe), .cmd_byte_enable_n_in(cbe_w),
		.cmd_byte_enable_n_out(cbe_out), .cmd_byte_enable_oe(cbe_oe), .par_in(par_w),
		.par_out(par_out), .par_oe(par_oe), .frame_n_in(frame_w), .frame_n_out(frame_n_out),
		.frame_oe(frame_oe), .initiator_ready_n_in(irdy_w), .initiator_ready_n_out(irdy_out),
		.initiator_ready_oe(irdy_oe), .target_ready_n(trdy_n), .system_error_n(system_error_n),
		.mst_start(mst_start), .mst_write(mst_write), .mst_cmd(mst_cmd), .mst_addr(mst_addr),
		.mst_count(mst_count), .mst_wdata(wword(xaddr, mst_phase)),
		.mst_be_n(bexp(xaddr, mst_phase)), .mst_busy(mst_busy), .mst_phase(mst_phase),
		.mst_ack(mst_ack), .mst_rdata(mst_rdata), .data_parity_err(data_parity_err),
		.tgt_rd_drive(tgt_rd_drive), .tgt_rdata(tgt_rdata), .tgt_wr_phase(1'b0));

	pci_far_model far (.ref_clk(ref_clk), .sys_rst(sys_rst), .host(host_mode_pin),
		.req_n(grant_one_or_guest_request_n), .frame_n(frame_w), .irdy_n(irdy_w),
		.cbe_n(cbe_w), .trdy_wait(trdy_wait), .gnt_wait(gnt_wait), .rd_base(rd_base),
		.gnt_n(m_gnt_n), .target_ready_n(trdy_n), .m_pad(m_pad), .m_pad_oe(m_pad_oe),
		.m_par(m_par), .m_par_oe(m_par_oe));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask : step

	// Monitor of the wires, sampled on every rising edge.
	always @(posedge ref_clk) begin
		pad_hold <= ~pad_w;
		cbe_hold <= ~cbe_w;
		par_hold <= ~par_w;
		if (!sys_rst) begin
			if (par_oe) check("parity", {31'h0, ^{prev_pad, prev_cbe, par_out}}, 0);
			if (irdy_oe && !frame_prev && !cap_cmd[0]) check("turnaround", {31'h0, pad_oe}, 0);
			if (frame_oe && !frame_n_out && frame_prev) begin
				cap_addr = pad_w;
				cap_cmd = cbe_w;
				check("own_request", {31'h0, grant_one_or_guest_request_n}, {31'h0, host_mode_pin});
				check("guest_grant", {31'h0, m_gnt_n}, {31'h0, host_mode_pin});
			end
			if (irdy_oe && !irdy_w && !trdy_n) begin
				wq.push_back(pad_w);
				bq.push_back(cbe_w);
			end
			if (mst_ack && !cap_cmd[0] && wq.size() > 0) check("rdata", mst_rdata, wq[$]);
			if (!host_mode_pin) check("reserved", {30'h0, grant_three_n, grant_two_n}, 3);
			else check("one_grant", ($countones({grant_three_n, grant_two_n,
				grant_one_or_guest_request_n}) < 2) ? 32'h1 : 32'h0, 0);
			check("data_parity", {31'h0, data_parity_err}, 0);
			prev_pad = pad_out;
			prev_cbe = cbe_out;
			frame_prev = frame_w;
		end
	end

	task automatic run_xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [7:0] cnt);
		int w;
		wq.delete();
		bq.delete();
		xaddr = addr;
		rd_base = ~addr;
		mst_cmd = cmd;
		mst_addr = addr;
		mst_write = cmd[0];
		mst_count = cnt;
		mst_start = 1'b1;
		step();
		mst_start = 1'b0;
		w = 0;
		while (mst_busy !== 1'b0 && w < 300) begin
			step();
			w++;
		end
		if (w == 300) begin
			n_mismatch++;
			summarize();
		end
		check("addr", cap_addr, addr);
		check("cmd", {28'h0, cap_cmd}, {28'h0, cmd});
		check("phases", 32'(wq.size()), (cnt == 8'h00) ? 32'h1 : 32'(cnt));
		check("phase_idx", {24'h0, mst_phase}, (cnt == 8'h00) ? 32'h1 : 32'(cnt));
		for (int k = 0; k <= cnt && k < wq.size(); k++) begin
			check("data", wq[k], cmd[0] ? wword(addr, 8'(k)) : rd_base + k);
			check("byte_en", {28'h0, bq[k]}, {28'h0, bexp(addr, 8'(k))});
		end
	endtask : run_xfer

	task automatic foreign(input logic bad);
		f_pad = seed;
		f_cbe = 4'h6;
		f_oe = 1'b1;
		step();
		f_oe = 1'b0;
		f_par = ^{f_pad, f_cbe} ^ bad;
		f_par_oe = 1'b1;
		check("serr_early", {31'h0, system_error_n}, 1);
		step();
		f_par_oe = 1'b0;
		check("serr", {31'h0, system_error_n}, {31'h0, !bad});
		step();
		check("serr_late", {31'h0, system_error_n}, 1);
	endtask : foreign

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		logic [2:0] seen, last, g;
		int w;
		{sys_rst, host_mode_pin, mst_start, mst_write, tgt_rd_drive, f_oe, f_par, f_par_oe} = 8'h80;
		{req_n, frame_prev, pad_hold, cbe_hold, par_hold} = {3'h7, 1'b1, 32'h0, 4'h0, 1'b0};
		{mst_addr, tgt_rdata, xaddr, rd_base, f_pad, cap_addr} = '0;
		{mst_cmd, f_cbe, cap_cmd, trdy_wait, gnt_wait, mst_count} = {20'h0, 8'h00};
		seed = 32'h74F5;
		repeat (10) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		repeat (3) step();
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(lfsr(seed));
			trdy_wait = (i == 0) ? 4'h0 : {1'b0, seed[14:12]};
			gnt_wait = {1'b0, seed[18:16]};
			run_xfer(cmds[i % 6], seed, (i < 2) ? 8'h03 : {6'h0, seed[9:8]});
		end
		foreign(1'b1);
		foreign(1'b0);
		tgt_rdata = seed;
		tgt_rd_drive = 1'b1;
		repeat (2) step();
		check("tgt_pad", pad_out, tgt_rdata);
		check("tgt_oe", {31'h0, pad_oe}, 1);
		tgt_rd_drive = 1'b0;
		repeat (3) step();
		host_mode_pin = 1'b1;
		repeat (6) step();
		for (int k = 0; k < 3; k++) begin
			req_n[k] = 1'b0;
			w = 0;
			while ({grant_three_n, grant_two_n, grant_one_or_guest_request_n} !== ~(3'h1 << k)
				&& w < 8) begin
				step();
				w++;
			end
			check("grant", {29'h0, grant_three_n, grant_two_n, grant_one_or_guest_request_n},
				{29'h0, ~(3'h1 << k)});
			req_n[k] = 1'b1;
			repeat (3) step();
			check("released", {29'h0, grant_three_n, grant_two_n, grant_one_or_guest_request_n},
				7);
		end
		seen = 3'h0;
		last = 3'h7;
		req_n = 3'h0;
		for (int r = 0; r < 9; r++) begin
			w = 0;
			g = {grant_three_n, grant_two_n, grant_one_or_guest_request_n};
			while ((g === 3'h7 || g === last) && w < 10) begin
				step();
				w++;
				g = {grant_three_n, grant_two_n, grant_one_or_guest_request_n};
			end
			seen = seen | ~g;
			last = g;
			req_n = req_n | ~g;
			repeat (2) step();
			req_n = 3'h0;
		end
		check("rotation", {29'h0, seen}, 7);
		req_n = 3'h7;
		repeat (3) step();
		run_xfer(4'h7, ~seed, 8'h02);
		summarize();
	end
endmodule : tb
